/* src/app_pkg.sv */
package app_pkg;
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_PORT0 = 8'h04;
   localparam logic [7:0] ADDR_PORT1 = 8'h08;
   localparam logic [7:0] ADDR_PORT2 = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] PORT_STRIDE = 8'h04;

   localparam int CFG_OV_BIT = 2;
   localparam int CFG_LF_BIT = 3;
   localparam int CFG_OV_POL = 4;
   localparam int CFG_LF_POL = 5;
   localparam int CFG_ENABLE = 7;

   localparam logic [1:0] WIDTH_8 = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] WIDTH_RESET = 2'h0;

   localparam int IRQ_RD_DONE = 0;
   localparam int IRQ_WR_DONE = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;

   localparam int DATA_W = 24;
   localparam logic [DATA_W-1:0] DATA_RESET = 24'h000000;
   localparam logic [2:0] LANES_8 = 3'h1;
   localparam logic [2:0] LANES_16 = 3'h3;
   localparam logic [2:0] LANES_24 = 3'h7;

   typedef struct packed {
      logic write_strobe_n;
      logic out_enable_n;
      logic chip_select_n;
   } hs_in_t;

   typedef struct packed {
      logic [1:0] width;
      logic out_valid_polarity;
      logic latch_free_polarity;
      logic enable;
   } cfg_t;

   localparam cfg_t CFG_RESET = '{WIDTH_RESET, 1'b0, 1'b0, 1'b0};
   localparam hs_in_t HS_IDLE = '{1'b1, 1'b1, 1'b1};
endpackage : app_pkg

/* src/assisted_parallel_port.sv */
// Summary of operation
// - Transfers are 8, 16 or 24 bits, chosen by config bits 1:0.
// - When enabled, handshake outputs drive push-pull; inputs are plain.
// - Latch-free pin tells the host more input data is accepted.
// - Output-valid pin tells the host outbound data is ready.
// - Active strobe latches the incoming pin data.
// - Active output enable drives latched data onto the pins.
// - Strobe and output enable count only while chip select is low.
// - Writing port 0 sets output-valid; it clears on output enable.
// - Reading port 0 sets latch-free; it clears on strobe.
// - Config bit 4 sets output-valid polarity; pin is opposite of bit.
// - Config bit 5 sets latch-free polarity; pin is opposite of bit.
// - Only a port 0 write raises output-valid in wide transfers.
// - Output enable with chip select low presents outbound data.
// - Output enable going inactive raises the read-done interrupt.
// - Strobe with chip select fills input latches, clears latch-free.
// - Strobe going inactive raises the write-done interrupt.
// - Reading port 0 reasserts latch-free status and pin.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module assisted_parallel_port (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire app_pkg::hs_in_t hs_i,
   input wire logic [app_pkg::DATA_W-1:0] data_i,
   output logic [app_pkg::DATA_W-1:0] data_o,
   output logic [app_pkg::DATA_W-1:0] data_oe_o,
   output logic latch_free_pin_o,
   output logic out_valid_pin_o,
   output logic [1:0] hs_oe_o,
   output logic irq_o
);
   import app_pkg::*;

   function automatic logic [2:0] lane_en(input logic [1:0] w);
      if (w == WIDTH_8) begin
         lane_en = LANES_8;
      end else if (w == WIDTH_16) begin
         lane_en = LANES_16;
      end else begin
         lane_en = LANES_24;
      end
   endfunction : lane_en

   function automatic logic addr_ok(input logic [7:0] a);
      if (a == ADDR_CFG || a == ADDR_PORT0 || a == ADDR_PORT1) begin
         addr_ok = 1'b1;
      end else if (a == ADDR_PORT2 || a == ADDR_IRQ_STAT) begin
         addr_ok = 1'b1;
      end else if (a == ADDR_IRQ_MASK) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   endfunction : addr_ok

   hs_in_t hs_s1_q;
   hs_in_t hs_s2_q;
   logic [DATA_W-1:0] dat_s1_q;
   logic [DATA_W-1:0] dat_s2_q;
   cfg_t cfg_q;
   logic [DATA_W-1:0] out_lat_q;
   logic [DATA_W-1:0] in_lat_q;
   logic ov_q;
   logic lf_q;
   logic stb_act_q;
   logic oe_act_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [DATA_W-1:0] data_q;
   logic [DATA_W-1:0] data_oe_q;
   logic lf_pin_q;
   logic ov_pin_q;
   logic [1:0] hs_oe_q;
   logic irq_q;

   logic stb_act;
   logic oe_act;
   logic stb_end;
   logic oe_end;
   logic apb_acc;
   logic wr_en;
   logic rd_en;
   logic wr_port0;
   logic rd_port0;
   logic ov_bit;
   logic lf_bit;
   logic [2:0] lanes;
   logic [31:0] rd_mux;
   logic [1:0] irq_set;

   // Pin synchronisers
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         hs_s1_q <= HS_IDLE;
         hs_s2_q <= HS_IDLE;
         dat_s1_q <= DATA_RESET;
         dat_s2_q <= DATA_RESET;
      end else begin
         hs_s1_q <= hs_i;
         hs_s2_q <= hs_s1_q;
         dat_s1_q <= data_i;
         dat_s2_q <= dat_s1_q;
      end
   end

   // Chip select gates strobe and output enable
   assign stb_act = cfg_q.enable & ~hs_s2_q.write_strobe_n
                    & ~hs_s2_q.chip_select_n;
   assign oe_act = cfg_q.enable & ~hs_s2_q.out_enable_n
                   & ~hs_s2_q.chip_select_n;
   assign stb_end = stb_act_q & ~stb_act;
   assign oe_end = oe_act_q & ~oe_act;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         stb_act_q <= 1'b0;
         oe_act_q <= 1'b0;
      end else begin
         stb_act_q <= stb_act;
         oe_act_q <= oe_act;
      end
   end

   // APB decode; effects at the completing edge
   assign apb_acc = psel_i & penable_i & pready_q;
   assign wr_en = apb_acc & pwrite_i;
   assign rd_en = apb_acc & ~pwrite_i;
   assign wr_port0 = wr_en & (paddr_i == ADDR_PORT0);
   assign rd_port0 = rd_en & (paddr_i == ADDR_PORT0);

   assign ov_bit = ~(ov_q ^ cfg_q.out_valid_polarity);
   assign lf_bit = ~(lf_q ^ cfg_q.latch_free_polarity);
   assign lanes = lane_en(cfg_q.width);

   always_comb begin
      rd_mux = 32'h00000000;
      if (paddr_i == ADDR_CFG) begin
         rd_mux[1:0] = cfg_q.width;
         rd_mux[CFG_OV_BIT] = ov_bit;
         rd_mux[CFG_LF_BIT] = lf_bit;
         rd_mux[CFG_OV_POL] = cfg_q.out_valid_polarity;
         rd_mux[CFG_LF_POL] = cfg_q.latch_free_polarity;
         rd_mux[CFG_ENABLE] = cfg_q.enable;
      end else if (paddr_i == ADDR_PORT0) begin
         rd_mux[7:0] = in_lat_q[7:0];
      end else if (paddr_i == ADDR_PORT1) begin
         rd_mux[7:0] = in_lat_q[15:8];
      end else if (paddr_i == ADDR_PORT2) begin
         rd_mux[7:0] = in_lat_q[23:16];
      end else if (paddr_i == ADDR_IRQ_STAT) begin
         rd_mux[1:0] = irq_stat_q;
      end else if (paddr_i == ADDR_IRQ_MASK) begin
         rd_mux[1:0] = irq_mask_q;
      end
   end

   // One wait state; data and error registered with ready
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= psel_i & penable_i & ~pready_q;
         if (psel_i & penable_i & ~pready_q) begin
            pslverr_q <= ~addr_ok(paddr_i);
            prdata_q <= pwrite_i ? 32'h00000000 : rd_mux;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // Configuration
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         cfg_q <= CFG_RESET;
      end else if (wr_en && paddr_i == ADDR_CFG) begin
         cfg_q.width <= pwdata_i[1:0];
         cfg_q.out_valid_polarity <= pwdata_i[CFG_OV_POL];
         cfg_q.latch_free_polarity <= pwdata_i[CFG_LF_POL];
         cfg_q.enable <= pwdata_i[CFG_ENABLE];
      end
   end

   // Outbound latches, one byte per port
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_out
         localparam logic [7:0] PADDR = 8'(ADDR_PORT0 + PORT_STRIDE * gi);
         always_ff @(posedge sys_clk_i) begin
            if (!resetn_i) begin
               out_lat_q[8*gi +: 8] <= 8'h00;
            end else if (wr_en && paddr_i == PADDR) begin
               out_lat_q[8*gi +: 8] <= pwdata_i[7:0];
            end
         end
      end
   endgenerate

   // Inbound latches follow the pins while strobe is active
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         in_lat_q <= DATA_RESET;
      end else if (stb_act) begin
         in_lat_q <= dat_s2_q;
      end
   end

   // Output-valid: port 0 write sets, set wins over clear
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ov_q <= 1'b0;
      end else if (wr_port0) begin
         ov_q <= 1'b1;
      end else if (oe_act) begin
         ov_q <= 1'b0;
      end
   end

   // Latch-free: port 0 read sets, set wins over clear
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         lf_q <= 1'b1;
      end else if (rd_port0) begin
         lf_q <= 1'b1;
      end else if (stb_act) begin
         lf_q <= 1'b0;
      end
   end

   // Interrupt status, write one to clear, set wins
   always_comb begin
      irq_set = 2'h0;
      irq_set[IRQ_RD_DONE] = oe_end;
      irq_set[IRQ_WR_DONE] = stb_end;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         irq_stat_q <= IRQ_RESET;
      end else if (wr_en && paddr_i == ADDR_IRQ_STAT) begin
         irq_stat_q <= irq_set | (irq_stat_q & ~pwdata_i[1:0]);
      end else begin
         irq_stat_q <= irq_set | irq_stat_q;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         irq_mask_q <= IRQ_RESET;
      end else if (wr_en && paddr_i == ADDR_IRQ_MASK) begin
         irq_mask_q <= pwdata_i[1:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Pin drivers
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         data_q <= DATA_RESET;
         data_oe_q <= DATA_RESET;
      end else begin
         data_q <= out_lat_q;
         data_oe_q <= oe_act ? {{8{lanes[2]}}, {8{lanes[1]}},
                                {8{lanes[0]}}} : DATA_RESET;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         lf_pin_q <= 1'b0;
         ov_pin_q <= 1'b0;
         hs_oe_q <= 2'h0;
      end else begin
         lf_pin_q <= ~lf_bit;
         ov_pin_q <= ~ov_bit;
         hs_oe_q <= {2{cfg_q.enable}};
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign data_o = data_q;
   assign data_oe_o = data_oe_q;
   assign latch_free_pin_o = lf_pin_q;
   assign out_valid_pin_o = ov_pin_q;
   assign hs_oe_o = hs_oe_q;
   assign irq_o = irq_q;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_oe_end;
      oe_act ##1 !oe_act;
   endsequence

   sequence s_stb_end;
      stb_act ##1 !stb_act;
   endsequence

   sequence s_port0_load;
      wr_port0 ##1 ov_q;
   endsequence

   sequence s_port0_unload;
      rd_port0 ##1 lf_q;
   endsequence

   AST_OV_SET: assert property (wr_port0 |=> ov_q)
      else $error("output valid not set by port 0 write");
   AST_OV_CLR: assert property (oe_act && !wr_port0 |=> !ov_q)
      else $error("output valid not cleared by output enable");
   AST_OV_ONLY0: assert property (!ov_q && !wr_port0 |=> !ov_q)
      else $error("output valid set without port 0 write");
   AST_LF_SET: assert property (rd_port0 |=> lf_q)
      else $error("latch free not set by port 0 read");
   AST_LF_CLR: assert property (stb_act && !rd_port0 |=> !lf_q)
      else $error("latch free not cleared by strobe");
   AST_OV_PIN: assert property (
      resetn_i && $stable(ov_bit) |=> out_valid_pin_o != $past(ov_bit))
      else $error("output valid pin not opposite of status bit");
   AST_LF_PIN: assert property (
      resetn_i && $stable(lf_bit) |=> latch_free_pin_o != $past(lf_bit))
      else $error("latch free pin not opposite of status bit");
   AST_RD_IRQ: assert property (
      s_oe_end |=> irq_stat_q[IRQ_RD_DONE])
      else $error("read done interrupt missing");
   AST_WR_IRQ: assert property (
      s_stb_end |=> irq_stat_q[IRQ_WR_DONE])
      else $error("write done interrupt missing");
   AST_CS_GATE: assert property (
      hs_s2_q.chip_select_n |=> data_oe_o == DATA_RESET)
      else $error("pins driven without chip select");
   AST_DRIVE: assert property (
      oe_act |=> data_oe_o[0] && data_o == $past(out_lat_q))
      else $error("latched data not presented");
   AST_WIDTH8: assert property (
      oe_act && cfg_q.width == WIDTH_8 |=> data_oe_o[23:8] == 16'h0000)
      else $error("upper lanes driven in 8 bit mode");
   AST_LATCH: assert property (
      stb_act |=> in_lat_q == $past(dat_s2_q))
      else $error("strobe did not latch data");
   AST_HS_OE: assert property (
      cfg_q.enable ##1 cfg_q.enable |-> hs_oe_o == 2'h3)
      else $error("handshake outputs not driven when enabled");
   AST_OV_HOLD: assert property (ov_q && !oe_act |=> ov_q)
      else $error("output valid dropped without output enable");
   AST_LF_HOLD: assert property (lf_q && !stb_act |=> lf_q)
      else $error("latch free dropped without strobe");
   AST_OV_PIN_SET: assert property (
      s_port0_load |=> out_valid_pin_o != cfg_q.out_valid_polarity)
      else $error("output valid pin not asserted after port 0 write");
   AST_LF_PIN_SET: assert property (
      s_port0_unload |=> latch_free_pin_o != cfg_q.latch_free_polarity)
      else $error("latch free pin not asserted after port 0 read");
   AST_IN_HOLD: assert property (!stb_act |=> $stable(in_lat_q))
      else $error("input latches changed without gated strobe");
   AST_OE_DROP: assert property (
      !oe_act |=> data_oe_o == DATA_RESET)
      else $error("pins driven without output enable");
   AST_IRQ_LEVEL: assert property (
      (|(irq_stat_q & irq_mask_q)) |=> irq_o)
      else $error("interrupt output not raised");
endmodule : assisted_parallel_port
`default_nettype wire

/* testbench/host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic clk_i,
   input wire logic [app_pkg::DATA_W-1:0] pin_i,
   input wire logic [app_pkg::DATA_W-1:0] pin_oe_i,
   output var app_pkg::hs_in_t hs_o,
   output logic [app_pkg::DATA_W-1:0] pin_o
);
   import app_pkg::*;
   initial begin
      hs_o = HS_IDLE;
      pin_o = DATA_RESET;
   end
   // Presents a word under strobe; sel low leaves chip select idle
   task automatic send(input logic [DATA_W-1:0] v, input logic sel);
      @(posedge clk_i);
      pin_o <= v;
      hs_o <= '{1'b0, 1'b1, ~sel};
      repeat (6) @(posedge clk_i);
      hs_o <= HS_IDLE;
      @(posedge clk_i);
      pin_o <= ~v;
   endtask : send
   // Reads the pins under output enable and chip select
   task automatic fetch(output logic [DATA_W-1:0] v,
      output logic [DATA_W-1:0] en);
      @(posedge clk_i);
      hs_o <= '{1'b1, 1'b0, 1'b0};
      repeat (6) @(posedge clk_i);
      v = pin_i;
      en = pin_oe_i;
      hs_o <= HS_IDLE;
   endtask : fetch
endmodule : host_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import app_pkg::*;
   logic sys_clk_i, resetn_i, psel_i, penable_i, pwrite_i;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rdat;
   logic pready_o, pslverr_o, rerr, latch_free_pin_o, out_valid_pin_o;
   logic irq_o;
   logic [1:0] hs_oe_o;
   hs_in_t hs_i;
   logic [DATA_W-1:0] data_i, data_o, data_oe_o, v, en;
   int mismatches = 0;
   int samples_checked = 0;
   assisted_parallel_port u_dut (.sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .hs_i(hs_i), .data_i(data_i), .data_o(data_o),
      .data_oe_o(data_oe_o), .latch_free_pin_o(latch_free_pin_o),
      .out_valid_pin_o(out_valid_pin_o), .hs_oe_o(hs_oe_o),
      .irq_o(irq_o));
   host_model u_host (.clk_i(sys_clk_i), .pin_i(data_o),
      .pin_oe_i(data_oe_o), .hs_o(hs_i), .pin_o(data_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   task automatic final_report;
      $display("mismatches %0d samples_checked %0d", mismatches,
         samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rdat, e);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : tick
   task automatic wirq(input logic e);
      int n;
      n = 0;
      while (irq_o !== e && n < 30) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk("irq", irq_o, e);
   endtask : wirq
   task automatic t_reset;
      rd(ADDR_CFG, 32'h04, "cfg reset");
      chk("lf pin idle", latch_free_pin_o, 1'b1);
      rd(ADDR_IRQ_STAT, 32'h0, "stat reset");
      rd(ADDR_IRQ_MASK, 32'h0, "mask reset");
   endtask : t_reset
   task automatic t_out;
      wr(ADDR_IRQ_MASK, 32'h3);
      wr(ADDR_CFG, 32'h92);
      rd(ADDR_CFG, 32'h92, "cfg 24 pol");
      chk("hs oe", hs_oe_o, 2'h3);
      wr(ADDR_PORT2, 32'hC3);
      wr(ADDR_PORT1, 32'hB2);
      tick(3);
      chk("ov pin upper", out_valid_pin_o, 1'b1);
      wr(ADDR_PORT0, 32'hA1);
      tick(3);
      chk("ov pin set", out_valid_pin_o, 1'b0);
      rd(ADDR_CFG, 32'h96, "ov status");
      u_host.fetch(v, en);
      chk("out data", v, 24'hC3B2A1);
      chk("out oe", en, 24'hFFFFFF);
      wirq(1'b1);
      rd(ADDR_IRQ_STAT, 32'h1, "rd done");
      chk("ov pin clr", out_valid_pin_o, 1'b1);
      wr(ADDR_IRQ_STAT, 32'h1);
      rd(ADDR_IRQ_STAT, 32'h0, "w1c");
      wirq(1'b0);
   endtask : t_out
   task automatic t_in;
      wr(ADDR_IRQ_MASK, 32'h0);
      wr(ADDR_CFG, 32'hA1);
      tick(2);
      chk("lf pin pol", latch_free_pin_o, 1'b0);
      rd(ADDR_CFG, 32'hAD, "lf status");
      u_host.send(24'h5A6978, 1'b1);
      chk("lf pin full", latch_free_pin_o, 1'b1);
      tick(6);
      chk("irq masked", irq_o, 1'b0);
      rd(ADDR_IRQ_STAT, 32'h2, "wr done");
      wr(ADDR_IRQ_MASK, 32'h2);
      wirq(1'b1);
      rd(ADDR_PORT1, 32'h69, "in byte1");
      tick(3);
      chk("lf pin p1", latch_free_pin_o, 1'b1);
      rd(ADDR_PORT0, 32'h78, "in byte0");
      tick(3);
      chk("lf pin p0", latch_free_pin_o, 1'b0);
      wr(ADDR_IRQ_STAT, 32'h2);
      wirq(1'b0);
      wr(ADDR_PORT0, 32'h5E);
      u_host.fetch(v, en);
      chk("w16 data", v[15:0], 16'hB25E);
      chk("w16 oe", en, 24'h00FFFF);
      tick(4);
      wr(ADDR_IRQ_STAT, 32'h1);
   endtask : t_in
   task automatic t_gate;
      wr(ADDR_CFG, 32'h80);
      u_host.send(24'h123456, 1'b0);
      tick(6);
      chk("lf pin cs", latch_free_pin_o, 1'b1);
      rd(ADDR_IRQ_STAT, 32'h0, "cs gate");
      wr(ADDR_PORT0, 32'h3C);
      u_host.fetch(v, en);
      chk("w8 data", v[7:0], 8'h3C);
      chk("w8 oe", en, 24'h0000FF);
      wr(ADDR_IRQ_STAT, 32'h1);
      wr(ADDR_CFG, 32'h00);
      tick(2);
      chk("hs oe off", hs_oe_o, 2'h0);
      rd(8'h18, 32'h0, "unmapped");
      chk("slverr", rerr, 1'b1);
   endtask : t_gate
   initial begin
      resetn_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      tick(20);
      resetn_i <= 1'b1;
      t_reset();
      t_out();
      t_in();
      t_gate();
      final_report();
   end
   initial begin
      tick(20000);
      mismatches++;
      final_report();
   end
endmodule : tb_top
`default_nettype wire
